// ---- pkg/cvr_params.svh ----
// named constants for the channel 6..10 volume register bank
// assumes: included by the package and by every design file that needs it
`ifndef CVR_PARAMS_SVH
`define CVR_PARAMS_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define CVR_NCH 5
`define CVR_IDX_W 3
`define CVR_ADDR_W 8
`define CVR_DATA_W 8
`define CVR_SMP_W 24
`define CVR_STATE_W 3

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define CVR_ADDR_CH6 8'h11
`define CVR_ADDR_CH7 8'h12
`define CVR_ADDR_CH8 8'h13
`define CVR_ADDR_CH9 8'h14
`define CVR_ADDR_CH10 8'h15
`define CVR_VOL_RST 8'h00
`define CVR_RD_NONE 8'h00
`define CVR_IDX_CH6 3'h0
`define CVR_IDX_CH7 3'h1
`define CVR_IDX_CH8 3'h2
`define CVR_IDX_CH9 3'h3
`define CVR_IDX_CH10 3'h4

// ----------------------------------------------------------------
// attenuation law: 375 milli-dB per code step, 16 steps per 6 dB
// ----------------------------------------------------------------
`define CVR_STEP_MDB 375
`define CVR_FINE_W 4
`define CVR_FINE_FRAC 16
`define CVR_GAIN_FRAC 24
`define CVR_FINE_GW 17
`define CVR_GAIN_W 25
`define CVR_UNITY 25'h1000000

`endif

// ---- pkg/cvr_pkg.sv ----
// types shared by the volume register bank and its gain stages
// assumes: cvr_params.svh is on the include path
`include "cvr_params.svh"

package cvr_pkg;

	// ------------------------------------------------------------
	// control port access state
	// ------------------------------------------------------------
	typedef enum logic [`CVR_STATE_W-1:0] {
		CVR_IDLE = 3'h1,
		CVR_ACCESS = 3'h2,
		CVR_RESP = 3'h4
	} cvr_state_e;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [`CVR_ADDR_W-1:0] addr;
		logic [`CVR_DATA_W-1:0] wdata;
	} cvr_req_s;

	typedef struct packed {
		logic valid;
		logic err;
		logic [`CVR_DATA_W-1:0] rdata;
	} cvr_rsp_s;

	typedef struct packed {
		logic valid;
		logic signed [`CVR_SMP_W-1:0] data;
	} cvr_smp_s;

	typedef struct packed {
		logic hit;
		logic [`CVR_IDX_W-1:0] idx;
	} cvr_dec_s;

	typedef logic [`CVR_DATA_W-1:0] cvr_vol_t;

endpackage

// ---- logic/cvr_gain.sv ----
// one channel's volume stage: code to linear gain, then sample scaling
// assumes: samples arrive as signed words with a valid strobe on clk
`include "cvr_params.svh"

module cvr_gain (
	input wire logic clk,
	input wire logic rst,
	input wire cvr_pkg::cvr_vol_t vol_code,
	input wire cvr_pkg::cvr_smp_s smp_in,
	output cvr_pkg::cvr_smp_s smp_out
);

	// ------------------------------------------------------------
	// gain tables
	// ------------------------------------------------------------
	// fine part: gain of 0..15 steps of 0.375 dB, unity = 2^16
	function automatic logic [`CVR_FINE_GW-1:0] fine_gain(
		input logic [`CVR_FINE_W-1:0] r
	);
		case (r)
			4'h0: fine_gain = 17'h10000;
			4'h1: fine_gain = 17'h0f52f;
			4'h2: fine_gain = 17'h0ead3;
			4'h3: fine_gain = 17'h0e0e7;
			4'h4: fine_gain = 17'h0d767;
			4'h5: fine_gain = 17'h0ce4c;
			4'h6: fine_gain = 17'h0c595;
			4'h7: fine_gain = 17'h0bd3b;
			4'h8: fine_gain = 17'h0b53c;
			4'h9: fine_gain = 17'h0ad93;
			4'ha: fine_gain = 17'h0a63e;
			4'hb: fine_gain = 17'h09f38;
			4'hc: fine_gain = 17'h0987d;
			4'hd: fine_gain = 17'h0920c;
			4'he: fine_gain = 17'h08be0;
			default: fine_gain = 17'h085f7;
		endcase
	endfunction

	// coarse part: gain of 0..15 blocks of 6 dB, unity = 2^24
	function automatic logic [`CVR_GAIN_W-1:0] coarse_gain(
		input logic [`CVR_FINE_W-1:0] q
	);
		case (q)
			4'h0: coarse_gain = 25'h1000000;
			4'h1: coarse_gain = 25'h0804dbb;
			4'h2: coarse_gain = 25'h0404dec;
			4'h3: coarse_gain = 25'h0203a88;
			4'h4: coarse_gain = 25'h0102710;
			4'h5: coarse_gain = 25'h008186e;
			4'h6: coarse_gain = 25'h0040eb0;
			4'h7: coarse_gain = 25'h0020893;
			4'h8: coarse_gain = 25'h00104e8;
			4'h9: coarse_gain = 25'h00082c3;
			4'ha: coarse_gain = 25'h0004189;
			4'hb: coarse_gain = 25'h00020d9;
			4'hc: coarse_gain = 25'h0001076;
			4'hd: coarse_gain = 25'h0000840;
			4'he: coarse_gain = 25'h0000423;
			default: coarse_gain = 25'h0000213;
		endcase
	endfunction

	// ------------------------------------------------------------
	// stage 1: capture sample and its gain together
	// ------------------------------------------------------------
	logic [`CVR_GAIN_W-1:0] gain_r, gain_nxt;
	cvr_pkg::cvr_smp_s s1_r, s1_nxt;
	cvr_pkg::cvr_smp_s out_r, out_nxt;
	logic [`CVR_FINE_GW+`CVR_GAIN_W-1:0] gprod;
	logic signed [`CVR_SMP_W+`CVR_GAIN_W:0] sprod;

	always_comb
	begin
		// 0.375 dB per step, code 0 gives exact unity
		gprod = fine_gain(vol_code[`CVR_FINE_W-1:0]) *
			coarse_gain(vol_code[`CVR_DATA_W-1:`CVR_FINE_W]);
		gain_nxt = `CVR_GAIN_W'(gprod >> `CVR_FINE_FRAC);
		if (vol_code == `CVR_VOL_RST)
			gain_nxt = `CVR_UNITY;
		s1_nxt = smp_in;
	end

	// ------------------------------------------------------------
	// stage 2: scale the sample
	// ------------------------------------------------------------
	always_comb
	begin
		sprod = s1_r.data * $signed({1'b0, gain_r});
		out_nxt.valid = s1_r.valid;
		out_nxt.data = sprod[`CVR_GAIN_FRAC+`CVR_SMP_W-1:`CVR_GAIN_FRAC];
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			gain_r <= `CVR_UNITY;
			s1_r <= '0;
			out_r <= '0;
		end
		else
		begin
			gain_r <= gain_nxt;
			s1_r <= s1_nxt;
			out_r <= out_nxt;
		end
	end

	assign smp_out = out_r;

endmodule

// ---- logic/cvr_top.sv ----
// volume register bank for output channels 6..10 and their gain stages
// assumes: the control port front end (serial or two-wire) has already
// turned host transfers into single-byte requests on clk; one request is
// outstanding at a time and is offered only while req_ready is high
`include "cvr_params.svh"

// Function
// - each increment of a channel's 8-bit code adds 0.375 dB of attenuation.
// - code 00000000 is 0 dB, 00000001 is -0.375 dB, 00000010 -0.750 dB, 0 is default.
// - code 11111110 gives -95.250 dB and 11111111 the deepest -95.625 dB.
// - channel 6 volume is an 8-bit read/write register at 0x11, reset 0.
// - channel 7 volume is an 8-bit read/write register at 0x12, reset 0.
// - channel 8 volume is an 8-bit read/write register at 0x13, reset 0.
// - channel 9 volume is an 8-bit read/write register at 0x14, reset 0.
// - channel 10 volume is an 8-bit read/write register at 0x15, reset 0.
module cvr_top (
	input wire logic clk,
	input wire logic rst,
	input wire cvr_pkg::cvr_req_s req,
	output logic req_ready,
	output cvr_pkg::cvr_rsp_s rsp,
	input wire cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_in,
	output cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_out,
	output cvr_pkg::cvr_vol_t [`CVR_NCH-1:0] vol_code
);

	// ------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------
	// control address of each channel's volume register
	function automatic logic [`CVR_ADDR_W-1:0] chan_addr(
		input logic [`CVR_IDX_W-1:0] idx
	);
		case (idx)
			`CVR_IDX_CH6: chan_addr = `CVR_ADDR_CH6;
			`CVR_IDX_CH7: chan_addr = `CVR_ADDR_CH7;
			`CVR_IDX_CH8: chan_addr = `CVR_ADDR_CH8;
			`CVR_IDX_CH9: chan_addr = `CVR_ADDR_CH9;
			default: chan_addr = `CVR_ADDR_CH10;
		endcase
	endfunction

	// match an address against the map; miss means unmapped
	function automatic cvr_pkg::cvr_dec_s decode(
		input logic [`CVR_ADDR_W-1:0] addr
	);
		cvr_pkg::cvr_dec_s d;
		d.hit = 1'b0;
		d.idx = '0;
		for (int i = 0; i < `CVR_NCH; i++)
		begin
			if (addr == chan_addr(`CVR_IDX_W'(i)))
			begin
				d.hit = 1'b1;
				d.idx = `CVR_IDX_W'(i);
			end
		end
		return d;
	endfunction

	// ------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------
	cvr_pkg::cvr_state_e state_r, state_nxt;
	cvr_pkg::cvr_req_s req_r, req_nxt;

	always_comb
	begin
		state_nxt = state_r;
		req_nxt = req_r;
		case (state_r)
			cvr_pkg::CVR_IDLE:
			begin
				if (req.valid)
				begin
					req_nxt = req;
					state_nxt = cvr_pkg::CVR_ACCESS;
				end
			end
			cvr_pkg::CVR_ACCESS:
			begin
				state_nxt = cvr_pkg::CVR_RESP;
			end
			cvr_pkg::CVR_RESP:
			begin
				req_nxt.valid = 1'b0;
				state_nxt = cvr_pkg::CVR_IDLE;
			end
			default:
			begin
				req_nxt = '0;
				state_nxt = cvr_pkg::CVR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= cvr_pkg::CVR_IDLE;
			req_r <= '0;
		end
		else
		begin
			state_r <= state_nxt;
			req_r <= req_nxt;
		end
	end

	// a new request is only taken when nothing is in flight
	assign req_ready = (state_r == cvr_pkg::CVR_IDLE);

	// ------------------------------------------------------------
	// volume registers
	// ------------------------------------------------------------
	cvr_pkg::cvr_vol_t [`CVR_NCH-1:0] vol_r, vol_nxt;
	cvr_pkg::cvr_dec_s dec;
	logic do_access;

	always_comb
	begin
		dec = decode(req_r.addr);
		do_access = (state_r == cvr_pkg::CVR_ACCESS);
		vol_nxt = vol_r;
		// only the addressed channel changes; writes elsewhere are dropped
		if (do_access && req_r.write && dec.hit)
			vol_nxt[dec.idx] = req_r.wdata;
	end

	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			for (int i = 0; i < `CVR_NCH; i++)
				vol_r[i] <= `CVR_VOL_RST;
		end
		else
		begin
			vol_r <= vol_nxt;
		end
	end

	assign vol_code = vol_r;

	// ------------------------------------------------------------
	// response
	// ------------------------------------------------------------
	cvr_pkg::cvr_rsp_s rsp_r, rsp_nxt;

	always_comb
	begin
		rsp_nxt = '0;
		if (do_access)
		begin
			rsp_nxt.valid = 1'b1;
			rsp_nxt.err = ~dec.hit;
			// reads return the stored code, writes echo the new value
			if (dec.hit && req_r.write)
				rsp_nxt.rdata = req_r.wdata;
			else if (dec.hit)
				rsp_nxt.rdata = vol_r[dec.idx];
			else
				rsp_nxt.rdata = `CVR_RD_NONE;
		end
	end

	always_ff @(posedge clk)
	begin
		if (rst)
			rsp_r <= '0;
		else
			rsp_r <= rsp_nxt;
	end

	assign rsp = rsp_r;

	// ------------------------------------------------------------
	// per-channel sample paths
	// ------------------------------------------------------------
	// each stage sees only its own register, so channels never interact
	for (genvar g = 0; g < `CVR_NCH; g++)
	begin : g_ch
		cvr_gain u_gain (
			.clk(clk),
			.rst(rst),
			.vol_code(vol_r[g]),
			.smp_in(smp_in[g]),
			.smp_out(smp_out[g])
		);
	end

endmodule

// ---- tb/cvr_top_assertions.sv ----
// assertions on the volume bank's control and sample ports
// assumes: bound to cvr_top, one clock, synchronous reset
`include "cvr_params.svh"
module cvr_top_assertions (
	input wire logic clk,
	input wire logic rst,
	input wire cvr_pkg::cvr_req_s req,
	input wire logic req_ready,
	input wire cvr_pkg::cvr_rsp_s rsp,
	input wire cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_in,
	input wire cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_out,
	input wire cvr_pkg::cvr_vol_t [`CVR_NCH-1:0] vol_code
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	logic tk;
	logic miss;
	assign tk = req.valid && req_ready;
	assign miss = req.addr < 8'h11 || req.addr > 8'h15;
	rsp_latency_a: assert property (
		tk |=> !rsp.valid ##1 rsp.valid)
		else $error("late response");
	busy_window_a: assert property (
		tk |=> !req_ready [*2] ##1 req_ready)
		else $error("ready window");
	rsp_pulse_a: assert property (
		rsp.valid |=> !rsp.valid)
		else $error("response too long");
	unmapped_err_a: assert property (
		tk && miss |-> ##2 rsp.err && rsp.rdata == 8'h00)
		else $error("unmapped access");
	write_echo_a: assert property (
		tk && req.write && !miss |-> ##2 !rsp.err
		&& rsp.rdata == $past(req.wdata, 2))
		else $error("write echo");
	ch6_write_a: assert property (
		tk && req.write && req.addr == 8'h11 |->
		##2 vol_code[0] == $past(req.wdata, 2))
		else $error("ch6 not written");
	ch10_write_a: assert property (
		tk && req.write && req.addr == 8'h15 |->
		##2 vol_code[4] == $past(req.wdata, 2))
		else $error("ch10 not written");
	code_hold_a: assert property (
		$changed(vol_code) |-> rsp.valid && !rsp.err)
		else $error("code changed without write");
	unity_path_a: assert property (
		smp_in[0].valid && vol_code[0] == 8'h00
		|=> ##1 smp_out[0] == $past(smp_in[0], 2))
		else $error("code zero not unity");
	valid_follow_a: assert property (
		!$past(rst, 1) && !$past(rst, 2) |->
		smp_out[4].valid == $past(smp_in[4].valid, 2))
		else $error("sample valid lost");
	cover property (tk && req.write && req.addr == 8'h11);
	cover property (tk && miss);
	cover property (smp_out[2].valid && vol_code[2] == 8'hff);
endmodule

bind cvr_top cvr_top_assertions i_cvr_top_assertions (.clk(clk), .rst(rst),
	.req(req), .req_ready(req_ready), .rsp(rsp), .smp_in(smp_in),
	.smp_out(smp_out), .vol_code(vol_code));

// ---- tb/cvr_host.sv ----
// host model: single-byte register accesses on the control port
// assumes: a request is held until taken, answer two edges later
module cvr_host (
	input wire logic clk,
	output cvr_pkg::cvr_req_s req,
	input wire logic req_ready,
	input wire cvr_pkg::cvr_rsp_s rsp
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '0;
	task automatic access(input logic wr, input logic [7:0] a,
		input logic [7:0] d, output cvr_pkg::cvr_rsp_s r);
		@(posedge clk);
		#1 req = {1'b1, wr, a, d};
		@(negedge clk);
		while (req_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		// released fields must not look like a live request
		#1 req = {1'b0, ~wr, ~a, ~d};
		// the one-cycle answer stands between the first and second edge
		// after the take, so read it at the second falling edge
		repeat (2) @(negedge clk);
		r = rsp;
	endtask
endmodule

// ---- tb/tb_cvr_top.sv ----
// self-checking bench for the channel 6..10 volume register bank
// assumes: cvr_host drives the control port, the bench drives samples
`include "cvr_params.svh"
module tb_cvr_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic rst;
	cvr_pkg::cvr_req_s req;
	logic req_ready;
	cvr_pkg::cvr_rsp_s rsp;
	cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_in;
	cvr_pkg::cvr_smp_s [`CVR_NCH-1:0] smp_out;
	cvr_pkg::cvr_vol_t [`CVR_NCH-1:0] vol_code;
	int num_errors;
	int compares;
	cvr_top i_cvr_top (.clk(clk), .rst(rst), .req(req), .req_ready(req_ready),
		.rsp(rsp), .smp_in(smp_in), .smp_out(smp_out), .vol_code(vol_code));
	cvr_host i_cvr_host (.clk(clk), .req(req), .req_ready(req_ready),
		.rsp(rsp));
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic acc(input logic wr, input logic [7:0] a,
		input logic [7:0] d, input logic err, input logic [7:0] exp);
		cvr_pkg::cvr_rsp_s r;
		i_cvr_host.access(wr, a, d, r);
		check("rsp.valid", r.valid, 1'b1);
		check("rsp.err", r.err, err);
		check("rsp.rdata", r.rdata, exp);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic test_reset();
		for (int i = 0; i < 5; i++)
		begin
			check("vol_code", vol_code[i], 8'h00);
			acc(1'b0, 8'h11 + 8'(i), 8'h00, 1'b0, 8'h00);
		end
	endtask
	task automatic test_rw();
		for (int i = 0; i < 5; i++)
			acc(1'b1, 8'h11 + 8'(i), 8'ha0 + 8'(i), 1'b0, 8'ha0 + 8'(i));
		for (int i = 0; i < 5; i++)
		begin
			check("vol_code", vol_code[i], 8'ha0 + 8'(i));
			acc(1'b0, 8'h11 + 8'(i), 8'h00, 1'b0, 8'ha0 + 8'(i));
		end
		acc(1'b1, 8'h10, 8'h33, 1'b1, 8'h00);
		acc(1'b0, 8'h16, 8'h00, 1'b1, 8'h00);
		check("vol_code", vol_code[0], 8'ha0);
	endtask
	task automatic test_rerst();
		@(posedge clk);
		#1 rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 5; i++)
			check("vol_code", vol_code[i], 8'h00);
		acc(1'b0, 8'h15, 8'h00, 1'b0, 8'h00);
		acc(1'b0, 8'h11, 8'h00, 1'b0, 8'h00);
	endtask
	task automatic test_gain();
		logic [7:0] codes [5] = '{8'h00, 8'h01, 8'h02, 8'hfe, 8'hff};
		real want;
		int got;
		acc(1'b1, 8'h11, 8'h00, 1'b0, 8'h00);
		for (int k = 0; k < 5; k++)
		begin
			acc(1'b1, 8'h13, codes[k], 1'b0, codes[k]);
			repeat (3) @(posedge clk);
			#1;
			got = smp_out[2].data;
			want = 4194304.0 * 10.0 ** (-0.375 * codes[k] / 20.0);
			check("gain", (got - want) ** 2 <= (want / 100.0 + 2.0) ** 2, 1'b1);
			check("ch6 out", smp_out[0].data, 24'h400000);
		end
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#100000;
		num_errors++;
		stop_test();
	end
	initial
	begin
		num_errors = 0;
		compares = 0;
		rst = 1'b1;
		smp_in = '0;
		repeat (4) @(posedge clk);
		#1 rst = 1'b0;
		for (int i = 0; i < 5; i++)
			smp_in[i] = {1'b1, 24'h400000};
		test_reset();
		test_rw();
		test_rerst();
		test_gain();
		stop_test();
	end
endmodule
